// ===== logic/flags_params.svh
/*
 holds the register offsets, field positions, reset values and sizes of the peripheral flag and reset cause bank.
 assumes inclusion by bare name from the top module; definitions only.
*/
`ifndef FLAGS_PARAMS_SVH
`define FLAGS_PARAMS_SVH

`define ADDR_W 5
`define SYNC_STAGES 2

`define OFS_PERIPH_FLAG 5'h00
`define OFS_RESET_CAUSE 5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_MASK 5'h0c
`define OFS_BOR_CTRL 5'h10
`define OFS_RESET_SOURCE 5'h14

`define BIT_CONV_DONE 6
`define BIT_CAP_CMP 5
`define BIT_CMP_CHANGE 3
`define BIT_PERIOD 1
`define BIT_OVERFLOW 0
`define FLAG_IMPL_MASK 8'h6b

`define BIT_POR_STAT 1
`define BIT_BOR_STAT 0
`define BIT_BOR_EN 0
`define BIT_SRC_WDT 0
`define BIT_SRC_EXT 1

`define RST_FLAGS 8'h00
`define RST_MASK 8'h00
`define RST_POR_STAT 1'b0
`define RST_BOR_STAT 1'b0
`define RST_BOR_EN 1'b1

`define HSIZE_WORD 3'h2

`endif

// ===== logic/flags_pkg.sv
/*
 holds the types of the flag bank: bus state and capture unit mode.
 assumes nothing of its surroundings.
*/
package flags_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_WRITE = 2'h1,
		BUS_RWAIT = 2'h3,
		BUS_RDATA = 2'h2
	} bus_state_t;

	typedef enum logic [1:0] {
		CCP_OFF = 2'h0,
		CCP_CAPTURE = 2'h1,
		CCP_COMPARE = 2'h2,
		CCP_PWM = 2'h3
	} ccp_mode_t;

endpackage

// ===== logic/periph_flags_top.sv
/*
 peripheral interrupt flag register, reset cause register and their interrupt status, mask and control,
 reached over an ahb-lite slave with 32-bit words.
 assumes peripheral event pulses on the system clock, an asynchronous comparator output and reset cause levels,
 and a power-on reset that only the supply monitor asserts.
*/
`include "flags_params.svh"

module periph_flags_top #(
	parameter int SYNC_STAGES = `SYNC_STAGES
) (
	input wire logic CLK_SYS_IN,
	input wire logic ARST_N_IN,
	input wire logic PWR_ON_RST_N_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic CONV_DONE_IN,
	input wire logic [1:0] CCP_MODE_IN,
	input wire logic CAPTURE_EVENT_IN,
	input wire logic COMPARE_MATCH_IN,
	input wire logic COMPARATOR_OUT_IN,
	input wire logic PERIOD_MATCH_IN,
	input wire logic OVERFLOW_IN,
	input wire logic BROWNOUT_CAUSE_IN,
	input wire logic WATCHDOG_CAUSE_IN,
	input wire logic EXT_PIN_CAUSE_IN,
	output logic [7:0] PERIPH_FLAGS_OUT,
	output logic BROWNOUT_ENABLE_OUT,
	output logic IRQ_OUT
);

	localparam int ADDR_W = `ADDR_W;

	flags_pkg::bus_state_t state;
	flags_pkg::bus_state_t next_state;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic word_size;
	logic next_word_size;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [7:0] rd_mux;
	logic take;
	logic wr_en;
	logic [7:0] wdata8;
	logic wr_flag;
	logic wr_cause;
	logic wr_status;
	logic wr_mask;
	logic wr_bor;
	logic wr_src;
	logic bor_view;

	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [7:0] mask;
	logic [7:0] next_mask;
	logic bor_en;
	logic next_bor_en;
	logic irq;
	logic next_irq;

	logic por_stat;
	logic next_por_stat;
	logic bor_stat;
	logic next_bor_stat;
	logic wdt_src;
	logic next_wdt_src;
	logic ext_src;
	logic next_ext_src;

	logic [3:0] async_lvl;
	logic [3:0] sync_lvl;
	logic [3:0] sync_chg;
	logic cap_cmp_hit;
	logic [7:0] ev;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	// comparator output and reset cause levels come from outside the clock
	assign async_lvl = {EXT_PIN_CAUSE_IN, WATCHDOG_CAUSE_IN, BROWNOUT_CAUSE_IN, COMPARATOR_OUT_IN};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			sync_edge #(
				.STAGES(SYNC_STAGES)
			) u_sync (
				.clk_in(CLK_SYS_IN),
				.arst_n_in(ARST_N_IN),
				.d_in(async_lvl[gi]),
				.level_out(sync_lvl[gi]),
				.change_out(sync_chg[gi])
			);
		end
	endgenerate

	// capture/compare event only counts in the matching mode
	always_comb begin
		cap_cmp_hit = 1'b0;
		unique case (flags_pkg::ccp_mode_t'(CCP_MODE_IN))
			flags_pkg::CCP_CAPTURE: cap_cmp_hit = CAPTURE_EVENT_IN;
			flags_pkg::CCP_COMPARE: cap_cmp_hit = COMPARE_MATCH_IN;
			flags_pkg::CCP_OFF, flags_pkg::CCP_PWM: cap_cmp_hit = 1'b0;
		endcase
	end

	always_comb begin
		ev = 8'h00;
		ev[`BIT_CONV_DONE] = CONV_DONE_IN;
		ev[`BIT_CAP_CMP] = cap_cmp_hit;
		ev[`BIT_CMP_CHANGE] = sync_chg[0];
		ev[`BIT_PERIOD] = PERIOD_MATCH_IN;
		ev[`BIT_OVERFLOW] = OVERFLOW_IN;
	end

	// ahb-lite slave: writes complete at once, reads take one wait cycle
	assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	assign wr_en = (state == flags_pkg::BUS_WRITE) && word_size;
	assign wdata8 = HWDATA_IN[7:0];
	// brown-out status is hidden while detection is off
	assign bor_view = bor_stat && bor_en;

	always_comb begin
		rd_mux = 8'h00;
		if (hit(addr, `OFS_PERIPH_FLAG)) begin
			rd_mux = flags & `FLAG_IMPL_MASK;
		end else if (hit(addr, `OFS_RESET_CAUSE)) begin
			rd_mux = 8'h00;
			rd_mux[`BIT_POR_STAT] = por_stat;
			rd_mux[`BIT_BOR_STAT] = bor_view;
		end else if (hit(addr, `OFS_IRQ_STATUS)) begin
			rd_mux = status;
		end else if (hit(addr, `OFS_IRQ_MASK)) begin
			rd_mux = mask;
		end else if (hit(addr, `OFS_BOR_CTRL)) begin
			rd_mux[`BIT_BOR_EN] = bor_en;
		end else if (hit(addr, `OFS_RESET_SOURCE)) begin
			rd_mux[`BIT_SRC_WDT] = wdt_src;
			rd_mux[`BIT_SRC_EXT] = ext_src;
		end
	end

	always_comb begin
		next_state = state;
		next_addr = addr;
		next_word_size = word_size;
		next_rdata = rdata;
		unique case (state)
			flags_pkg::BUS_RWAIT: begin
				next_rdata = {24'h000000, rd_mux};
				next_state = flags_pkg::BUS_RDATA;
			end
			flags_pkg::BUS_IDLE, flags_pkg::BUS_WRITE, flags_pkg::BUS_RDATA: begin
				if (take) begin
					next_addr = HADDR_IN[ADDR_W-1:0];
					next_word_size = (HSIZE_IN == `HSIZE_WORD);
					next_state = HWRITE_IN ? flags_pkg::BUS_WRITE : flags_pkg::BUS_RWAIT;
				end else begin
					next_state = flags_pkg::BUS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state <= flags_pkg::BUS_IDLE;
			addr <= '0;
			word_size <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			state <= next_state;
			addr <= next_addr;
			word_size <= next_word_size;
			rdata <= next_rdata;
		end
	end

	assign HRDATA_OUT = rdata;
	assign HREADYOUT_OUT = (state != flags_pkg::BUS_RWAIT);
	assign HRESP_OUT = 1'b0;

	// one write strobe per register, decoded once from the latched address
	always_comb begin
		wr_flag = wr_en && hit(addr, `OFS_PERIPH_FLAG);
		wr_cause = wr_en && hit(addr, `OFS_RESET_CAUSE);
		wr_status = wr_en && hit(addr, `OFS_IRQ_STATUS);
		wr_mask = wr_en && hit(addr, `OFS_IRQ_MASK);
		wr_bor = wr_en && hit(addr, `OFS_BOR_CTRL);
		wr_src = wr_en && hit(addr, `OFS_RESET_SOURCE);
	end

	// peripheral flags; device reset
	always_comb begin
		next_flags = flags;
		if (wr_flag) begin
			next_flags = wdata8;
		end
		// sticky flags: a same-cycle event wins over a written zero
		next_flags = (next_flags | ev) & `FLAG_IMPL_MASK;
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			flags <= `RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

	// interrupt status, mask and the registered level output
	always_comb begin
		next_status = status;
		next_mask = mask;
		if (wr_status) begin
			next_status = status & ~wdata8;
		end
		next_status = (next_status | ev) & `FLAG_IMPL_MASK;
		if (wr_mask) begin
			next_mask = wdata8 & `FLAG_IMPL_MASK;
		end
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			status <= `RST_FLAGS;
			mask <= `RST_MASK;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			mask <= next_mask;
			irq <= next_irq;
		end
	end

	// brown-out software enable
	always_comb begin
		next_bor_en = bor_en;
		if (wr_bor) begin
			next_bor_en = wdata8[`BIT_BOR_EN];
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bor_en <= `RST_BOR_EN;
		end else begin
			bor_en <= next_bor_en;
		end
	end

	assign PERIPH_FLAGS_OUT = flags;
	assign BROWNOUT_ENABLE_OUT = bor_en;
	assign IRQ_OUT = irq;

	// reset cause bits survive device reset; of the two resets, only power-on clears them
	always_comb begin
		next_por_stat = por_stat;
		next_bor_stat = bor_stat;
		next_wdt_src = wdt_src;
		next_ext_src = ext_src;
		if (wr_cause) begin
			next_por_stat = wdata8[`BIT_POR_STAT];
			next_bor_stat = wdata8[`BIT_BOR_STAT];
		end
		// a standing brown-out cause holds the bit at zero
		if (sync_lvl[1]) begin
			next_bor_stat = 1'b0;
		end
		if (wr_src) begin
			next_wdt_src = wdt_src & ~wdata8[`BIT_SRC_WDT];
			next_ext_src = ext_src & ~wdata8[`BIT_SRC_EXT];
		end
		next_wdt_src = next_wdt_src | (sync_chg[2] & sync_lvl[2]);
		next_ext_src = next_ext_src | (sync_chg[3] & sync_lvl[3]);
	end

	always_ff @(posedge CLK_SYS_IN or negedge PWR_ON_RST_N_IN) begin
		if (!PWR_ON_RST_N_IN) begin
			por_stat <= `RST_POR_STAT;
			bor_stat <= `RST_BOR_STAT;
			wdt_src <= 1'b0;
			ext_src <= 1'b0;
		end else begin
			por_stat <= next_por_stat;
			bor_stat <= next_bor_stat;
			wdt_src <= next_wdt_src;
			ext_src <= next_ext_src;
		end
	end

endmodule

// ===== logic/sync_edge.sv
/*
 synchroniser of STAGES stages (two by default) with a registered change detector behind the last stage.
 assumes an asynchronous input and one clock; reset value of every stage is zero.
*/
module sync_edge #(
	parameter int STAGES = 2
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic d_in,
	output logic level_out,
	output logic change_out
);

	logic [STAGES-1:0] chain;
	logic [STAGES-1:0] next_chain;
	logic last;
	logic next_last;

	always_comb begin
		next_chain = {chain[STAGES-2:0], d_in};
		next_last = chain[STAGES-1];
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chain <= '0;
			last <= 1'b0;
		end else begin
			chain <= next_chain;
			last <= next_last;
		end
	end

	// only the final stage is looked at
	assign level_out = chain[STAGES-1];
	assign change_out = chain[STAGES-1] ^ last;

endmodule

// ===== tb/flags_properties.sv
/*
 checker of the flag bank ports: flag setting, clearing and bus timing.
 assumes binding to the top module and a single clock domain.
*/
module flags_chk (
	input wire logic CLK_SYS_IN,
	input wire logic ARST_N_IN,
	input wire logic HSEL_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic HREADY_IN,
	input wire logic HREADYOUT_OUT,
	input wire logic [1:0] CCP_MODE_IN,
	input wire logic CONV_DONE_IN,
	input wire logic CAPTURE_EVENT_IN,
	input wire logic COMPARE_MATCH_IN,
	input wire logic COMPARATOR_OUT_IN,
	input wire logic PERIOD_MATCH_IN,
	input wire logic OVERFLOW_IN,
	input wire logic [7:0] PERIPH_FLAGS_OUT,
	input wire logic IRQ_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire acc = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	wire wr_t = acc && HWRITE_IN;
	wire rd_t = acc && !HWRITE_IN;
	ovf_set_a: assert property (OVERFLOW_IN |=> PERIPH_FLAGS_OUT[0])
		else $error("overflow flag not set");
	period_set_a: assert property (PERIOD_MATCH_IN |=> PERIPH_FLAGS_OUT[1])
		else $error("period flag not set");
	conv_set_a: assert property (CONV_DONE_IN |=> PERIPH_FLAGS_OUT[6])
		else $error("conversion flag not set");
	capcmp_set_a: assert property ((CAPTURE_EVENT_IN && CCP_MODE_IN == 2'h1)
		|| (COMPARE_MATCH_IN && CCP_MODE_IN == 2'h2) |=> PERIPH_FLAGS_OUT[5])
		else $error("capture compare flag not set");
	cmp_set_a: assert property ($changed(COMPARATOR_OUT_IN) |-> ##[1:5] PERIPH_FLAGS_OUT[3])
		else $error("comparator flag not set");
	unimpl_zero_a: assert property ((PERIPH_FLAGS_OUT & 8'h94) == 8'h00)
		else $error("unimplemented flag bit set");
	flag_hold_a: assert property (|($past(PERIPH_FLAGS_OUT) & ~PERIPH_FLAGS_OUT) |-> $past(wr_t, 2))
		else $error("flag dropped without a write");
	rd_wait_a: assert property (rd_t |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
		else $error("read wait state wrong");
	wr_nowait_a: assert property (wr_t |=> HREADYOUT_OUT)
		else $error("write data phase stalled");
	ovf_c: cover property (OVERFLOW_IN);
	rd_c: cover property (rd_t);
	irq_c: cover property ($rose(IRQ_OUT));
endmodule

bind periph_flags_top flags_chk u_chk (.CLK_SYS_IN, .ARST_N_IN, .HSEL_IN, .HTRANS_IN, .HWRITE_IN, .HREADY_IN,
	.HREADYOUT_OUT, .CCP_MODE_IN, .CONV_DONE_IN, .CAPTURE_EVENT_IN, .COMPARE_MATCH_IN, .COMPARATOR_OUT_IN,
	.PERIOD_MATCH_IN, .OVERFLOW_IN, .PERIPH_FLAGS_OUT, .IRQ_OUT);

// ===== tb/tb.sv
/*
 self-checking bench of the flag bank over ahb-lite.
 assumes the design files under logic/ and the checker bound to the top.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS_IN = 1'b0, ARST_N_IN = 1'b0, HWRITE_IN = 1'b0, cmp = 1'b0, bo = 1'b0, wd = 1'b0, ext = 1'b0;
	logic [1:0] HTRANS_IN = '0, CCP_MODE_IN = '0;
	logic [31:0] HADDR_IN = '0, HWDATA_IN = '0, HRDATA_OUT, seed = 32'hff88;
	logic [4:0] ev = '0;
	logic [7:0] PERIPH_FLAGS_OUT;
	logic HREADYOUT_OUT, IRQ_OUT;
	int n_fail = 0, checks_done = 0, m = 0;
	int bit_of[5] = '{6, 5, 5, 1, 0};
	// register model by word index: flags, cause, status, mask, enable, source
	int mdl[6] = '{0, 0, 0, 0, 1, 0};
	periph_flags_top i_dut (.CLK_SYS_IN, .ARST_N_IN, .PWR_ON_RST_N_IN(ARST_N_IN), .HSEL_IN(1'b1), .HADDR_IN,
		.HTRANS_IN, .HWRITE_IN, .HSIZE_IN(3'h2), .HWDATA_IN, .HREADY_IN(HREADYOUT_OUT), .HRDATA_OUT,
		.HREADYOUT_OUT, .HRESP_OUT(), .CONV_DONE_IN(ev[0]), .CCP_MODE_IN, .CAPTURE_EVENT_IN(ev[1]),
		.COMPARE_MATCH_IN(ev[2]), .COMPARATOR_OUT_IN(cmp), .PERIOD_MATCH_IN(ev[3]), .OVERFLOW_IN(ev[4]),
		.BROWNOUT_CAUSE_IN(bo), .WATCHDOG_CAUSE_IN(wd), .EXT_PIN_CAUSE_IN(ext), .PERIPH_FLAGS_OUT,
		.BROWNOUT_ENABLE_OUT(), .IRQ_OUT);
	initial begin
		forever #25 CLK_SYS_IN = ~CLK_SYS_IN;
	end
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int mdl_rd(logic [31:0] a);
		if (a[4:2] == 3'h1) return mdl[1] & (mdl[4] != 0 ? 3 : 2);
		if (a[4:2] > 3'h5) return 0;
		return mdl[a[4:2]];
	endfunction
	task automatic give_verdict();
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task automatic xfer(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge CLK_SYS_IN);
		HTRANS_IN <= 2'h2;
		HADDR_IN <= a;
		HWRITE_IN <= w;
		do @(posedge CLK_SYS_IN); while (HREADYOUT_OUT !== 1'b1 && ++n < 20);
		HTRANS_IN <= 2'h0;
		HWDATA_IN <= d;
		do @(posedge CLK_SYS_IN); while (HREADYOUT_OUT !== 1'b1 && ++n < 20);
		r = HRDATA_OUT;
		if (n >= 20) n_fail++;
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
		case (a[4:2])
			3'h0: mdl[0] = d & 32'h6b;
			3'h1: mdl[1] = d & 32'h3;
			3'h2: mdl[2] = mdl[2] & ~d;
			3'h3: mdl[3] = d & 32'h6b;
			3'h4: mdl[4] = d & 32'h1;
			3'h5: mdl[5] = mdl[5] & ~d;
			default: ;
		endcase
	endtask
	task automatic rd(logic [31:0] a, logic [31:0] e, string s);
		logic [31:0] r;
		xfer(1'b0, a, '0, r);
		chk(s, e, r);
		chk({s, "_model"}, mdl_rd(a), r);
	endtask
	task automatic pulse(int k);
		@(posedge CLK_SYS_IN);
		ev[k] <= 1'b1;
		@(posedge CLK_SYS_IN);
		ev <= '0;
		if ((k != 1 && k != 2) || CCP_MODE_IN == k) begin
			mdl[0] |= 1 << bit_of[k];
			mdl[2] |= 1 << bit_of[k];
		end
		@(posedge CLK_SYS_IN);
		chk("flag_model", mdl[0], PERIPH_FLAGS_OUT);
	endtask
	initial begin
		#100us;
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge CLK_SYS_IN);
		ARST_N_IN <= 1'b1;
		rd(32'h4, '0, "cause");
		rd(32'h10, 32'h1, "bor_en");
		rd(32'h1c, '0, "unmapped");
		for (int k = 0; k < 5; k++) begin
			wr(32'h0, '0);
			CCP_MODE_IN <= (k == 2) ? 2'h2 : 2'h1;
			pulse(k);
			m = 1 << bit_of[k];
			chk("flags", m, PERIPH_FLAGS_OUT);
		end
		CCP_MODE_IN <= 2'h3;
		pulse(1);
		chk("pwm", m, PERIPH_FLAGS_OUT);
		cmp <= 1'b1;
		mdl[0] |= 8;
		mdl[2] |= 8;
		repeat (6) @(posedge CLK_SYS_IN);
		rd(32'h0, m | 8, "cmp");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(32'h0, seed);
			rd(32'h0, seed[7:0] & 8'h6b, "flag_wr");
		end
		fork
			wr(32'h0, '0);
			begin
				repeat (2) @(posedge CLK_SYS_IN);
				ev[4] <= 1'b1;
				@(posedge CLK_SYS_IN);
				ev <= '0;
			end
		join
		mdl[0] |= 1;
		mdl[2] |= 1;
		rd(32'h0, 32'h1, "set_wins");
		wr(32'h8, 32'hff);
		wr(32'hc, 32'h1);
		chk("irq_clr", 0, IRQ_OUT);
		pulse(4);
		@(posedge CLK_SYS_IN);
		chk("irq_on", 1, IRQ_OUT);
		wr(32'h8, 32'h1);
		wr(32'hc, '0);
		pulse(4);
		@(posedge CLK_SYS_IN);
		chk("irq_mask", 0, IRQ_OUT);
		rd(32'h8, 32'h1, "status");
		wr(32'h4, 32'hff);
		rd(32'h4, 32'h3, "cause_set");
		wr(32'h10, '0);
		rd(32'h4, 32'h2, "bor_off");
		wr(32'h10, 32'h1);
		bo <= 1'b1;
		mdl[1] &= 32'h2;
		repeat (6) @(posedge CLK_SYS_IN);
		rd(32'h4, 32'h2, "bor_rst");
		bo <= 1'b0;
		repeat (3) @(posedge CLK_SYS_IN);
		wr(32'h4, 32'h3);
		rd(32'h4, 32'h3, "bor_rearm");
		wd <= 1'b1;
		mdl[5] |= 1;
		repeat (6) @(posedge CLK_SYS_IN);
		rd(32'h14, 32'h1, "wdt");
		ext <= 1'b1;
		mdl[5] |= 2;
		repeat (6) @(posedge CLK_SYS_IN);
		rd(32'h14, 32'h3, "ext");
		give_verdict();
	end
endmodule
